// file: design/cfg_port_pkg.sv
package cfg_port_pkg;
  // serial word layout
  localparam int WORD_W   = 32;
  localparam int SEL_W    = 3;
  localparam int NUM_REGS = 6;
  localparam int IDX_W    = 3;
  // control field positions inside the word
  localparam int R2_DBUF_DIV_BIT = 13;  // divider double buffer enable in register 2
  localparam int R2_MUX_LSB      = 26;  // test output select field in register 2
  localparam int R2_MUX_W        = 3;
  localparam int R2_PDN_BIT      = 5;   // software power-down in register 2
  localparam int R4_MUTE_BIT     = 5;   // software rf output enable in register 4
  localparam int R4_MTLD_BIT     = 10;  // mute until lock
  localparam int R4_DIV_LSB      = 20;  // divider select field in register 4
  localparam int R4_DIV_W        = 3;
  localparam int R0_IDX          = 0;
  localparam int R2_IDX          = 2;
  localparam int R4_IDX          = 4;
  localparam logic [WORD_W-1:0] REG_RESET = 32'h0000_0000;
  // test output selections
  typedef enum logic [2:0] {
    MUX_TRISTATE = 3'b000,
    MUX_HIGH     = 3'b001,
    MUX_LOW      = 3'b010,
    MUX_REFDIV   = 3'b011,
    MUX_FBDIV    = 3'b100,
    MUX_ALOCK    = 3'b101,
    MUX_DLOCK    = 3'b110,
    MUX_RSVD     = 3'b111
  } mux_sel_t;
  // three-flop synchroniser state for the serial pins
  typedef struct packed {
    logic [2:0] sclk;
    logic [2:0] sdata;
    logic [2:0] strobe;
  } pin_sync_t;
  // analog side status travelling into the port
  typedef struct packed {
    logic locked;
    logic fb_div;
    logic ref_div;
  } pll_status_t;
endpackage

// file: design/pin_sync3.sv
`timescale 1ns/1ps
// three flops per pin; an edge counts when flops two and three disagree
module pin_sync3 (
  // clock and reset
  input  wire logic                    i_mclk,
  input  wire logic                    i_rst,
  input  wire logic                    i_ce,
  // raw pins
  input  wire logic                    i_sclk,
  input  wire logic                    i_sdata,
  input  wire logic                    i_strobe,
  // synchronised pins
  output cfg_port_pkg::pin_sync_t      o_sync
);
  import cfg_port_pkg::*;

  pin_sync_t state_q, state_d;

  // shift each pin one stage deeper
  always_comb begin
    state_d       = state_q;
    state_d.sclk  = {state_q.sclk[1:0], i_sclk};
    state_d.sdata = {state_q.sdata[1:0], i_sdata};
    state_d.strobe = {state_q.strobe[1:0], i_strobe};
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      state_q <= '0;
    end else if (i_ce) begin
      state_q <= state_d;
    end
  end

  assign o_sync = state_q;
endmodule // pin_sync3

// file: design/serial_config_load_port.sv
`timescale 1ns/1ps
// Operation
// - shift data into 32-bit register on clock rise
// - strobe rise copies word to selected register
// - enable low powers down, pump tri-stated
// - enable high powers up per software bits
// - mute pin low or software bit mutes
// - lock indicator high locked, low unlocked
// - test output picks lock, feedback, reference
// - codes 000 to 101 select registers 0-5
// - double-buffered settings apply on register 0 write
module serial_config_load_port #(
  parameter int WORD_W = cfg_port_pkg::WORD_W,
  parameter int NUM_REGS = cfg_port_pkg::NUM_REGS
) (
  // clock, reset, enable
  input  wire logic                         i_mclk,
  input  wire logic                         i_rst,
  input  wire logic                         i_ce,
  // serial pins
  input  wire logic                         i_sclk,
  input  wire logic                         i_sdata,
  input  wire logic                         i_load_strobe,
  // control pins
  input  wire logic                         i_chip_enable,
  input  wire logic                         i_rf_mute_n,
  // analog side status
  input  cfg_port_pkg::pll_status_t         i_status,
  // configuration and status outputs
  output logic [WORD_W-1:0]                 o_reg_active [NUM_REGS],
  output logic [WORD_W-1:0]                 o_div_active,
  output logic                              o_powered,
  output logic                              o_pump_output_oe_n,
  output logic                              o_rf_enable,
  output logic                              o_lock_indicator,
  output logic                              o_test_select_out,
  output logic                              o_test_select_out_oe_n
);
  import cfg_port_pkg::*;

  // limitation: every pin is sampled by i_mclk through three flops, so each
  // serial clock phase must last at least three i_mclk cycles, and data must
  // be settled at least one i_mclk cycle before the serial clock rises
  // the level pins (enable, mute, lock, divider taps) see the same delay

  typedef struct packed {
    logic [WORD_W-1:0]          shift;
    logic [NUM_REGS-1:0][WORD_W-1:0] latch;   // first buffer
    logic [NUM_REGS-1:0][WORD_W-1:0] active;  // values in use
    logic [WORD_W-1:0]          div_act;
    logic [2:0]                 ctl_sync;     // chip enable, mute, locked
    logic [2:0]                 ctl_sync2;
    logic [2:0]                 ctl_sync3;
    logic [1:0]                 div_sync;     // feedback and reference dividers
    logic [1:0]                 div_sync2;
    logic [1:0]                 div_sync3;
    logic                       powered;
    logic                       pump_oe_n;
    logic                       rf_en;
    logic                       lock_ind;
    logic                       mux_out;
    logic                       mux_oe_n;
  } state_t;

  state_t    q, d;
  pin_sync_t sync;

  // target register is valid only for codes below the register count
  // codes 110 and 111 fall outside and leave every latch untouched
  function automatic logic sel_valid(input logic [SEL_W-1:0] sel);
    return int'(sel) < NUM_REGS;
  endfunction

  // true when the select code names the given register index
  // used for the commit and the divider decisions alike
  function automatic logic sel_is(input logic [SEL_W-1:0] sel, input int idx);
    return int'(sel) == idx;
  endfunction

  // a level pin counts as high only once two flop stages agree on it
  // a pin that is still settling therefore reads low
  function automatic logic agreed(input logic a, input logic b);
    return a & b;
  endfunction

  pin_sync3 u_sync (
    .i_mclk   (i_mclk),
    .i_rst    (i_rst),
    .i_ce     (i_ce),
    .i_sclk   (i_sclk),
    .i_sdata  (i_sdata),
    .i_strobe (i_load_strobe),
    .o_sync   (sync)
  );

  logic sclk_rise;
  logic strobe_rise;
  logic [SEL_W-1:0] sel;
  logic pin_ce, pin_mute_n, pin_locked;
  logic pin_fb_div, pin_ref_div;
  logic is_r0, is_r4, r4_held;
  mux_sel_t mux_sel;

  // edges seen when the second and third flop disagree
  // the third flop holds the older level, so a rise reads as 1 over 0
  assign sclk_rise   = sync.sclk[1] & ~sync.sclk[2];
  assign strobe_rise = sync.strobe[1] & ~sync.strobe[2];
  assign sel         = q.shift[SEL_W-1:0];  // control bits arrive last

  // level pins count once the second and third flops agree
  assign pin_ce      = agreed(q.ctl_sync2[2], q.ctl_sync3[2]);
  assign pin_mute_n  = agreed(q.ctl_sync2[1], q.ctl_sync3[1]);
  assign pin_locked  = agreed(q.ctl_sync2[0], q.ctl_sync3[0]);
  assign pin_fb_div  = agreed(q.div_sync2[1], q.div_sync3[1]);
  assign pin_ref_div = agreed(q.div_sync2[0], q.div_sync3[0]);
  assign mux_sel     = mux_sel_t'(q.active[R2_IDX][R2_MUX_LSB +: R2_MUX_W]);

  // commit decode for the word now in the shift register
  assign is_r0   = sel_is(sel, R0_IDX);
  assign is_r4   = sel_is(sel, R4_IDX);
  // divider select waits for register zero while double buffering is on
  assign r4_held = is_r4 & q.active[R2_IDX][R2_DBUF_DIV_BIT];

  // next-state logic for shift, latches and pins
  always_comb begin
    d = q;

    // three-stage synchronisers for the level pins
    d.ctl_sync  = {i_chip_enable, i_rf_mute_n, i_status.locked};
    d.ctl_sync2 = q.ctl_sync;
    d.ctl_sync3 = q.ctl_sync2;
    d.div_sync  = {i_status.fb_div, i_status.ref_div};
    d.div_sync2 = q.div_sync;
    d.div_sync3 = q.div_sync2;

    // serial data enters at the bottom and moves toward the msb
    // data comes from the third flop, which lines up with the clock
    // edge seen between the second and third flops
    if (sclk_rise) begin
      d.shift = {q.shift[WORD_W-2:0], sync.sdata[2]};  // msb first
    end

    // strobe commit: latch first, then decide what goes live
    if (strobe_rise && sel_valid(sel)) begin
      d.latch[sel] = q.shift;
      if (is_r0) begin
        // register zero releases every buffered setting at once
        d.active = d.latch;  // commit buffered settings
        if (d.latch[R2_IDX][R2_DBUF_DIV_BIT]) begin
          d.div_act = d.latch[R4_IDX];
        end
      end else if (!r4_held) begin
        // other registers take effect on their own strobe
        d.active[sel] = q.shift;
        if (is_r4) begin
          d.div_act = q.shift;
        end
      end
    end

    // power follows pin and software bit
    d.powered   = pin_ce & ~q.active[R2_IDX][R2_PDN_BIT];
    // pump is released whenever the device is not powered
    d.pump_oe_n = ~d.powered;

    // rf on while powered unless pin or software mute, or waiting for lock
    d.rf_en = d.powered & pin_mute_n & q.active[R4_IDX][R4_MUTE_BIT]
              & ~(q.active[R4_IDX][R4_MTLD_BIT] & ~pin_locked);

    // lock indicator follows the synchronised loop status
    d.lock_ind = pin_locked;

    // test output multiplexer
    // three-state code releases the pin, reserved code drives low
    d.mux_oe_n = 1'b0;
    case (mux_sel)
      MUX_TRISTATE: begin
        d.mux_out  = 1'b0;
        d.mux_oe_n = 1'b1;
      end
      MUX_HIGH:   d.mux_out = 1'b1;
      MUX_LOW:    d.mux_out = 1'b0;
      MUX_REFDIV: d.mux_out = pin_ref_div;
      MUX_FBDIV:  d.mux_out = pin_fb_div;
      MUX_ALOCK:  d.mux_out = pin_locked;
      MUX_DLOCK:  d.mux_out = pin_locked;
      default:    d.mux_out = 1'b0;
    endcase
  end

  // state register; reset clears every latch and releases both
  // three-state outputs, a low enable freezes everything
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      q           <= '0;
      q.latch     <= {NUM_REGS{REG_RESET}};
      q.active    <= {NUM_REGS{REG_RESET}};
      q.pump_oe_n <= 1'b1;
      q.mux_oe_n  <= 1'b1;
    end else if (i_ce) begin
      q <= d;
    end
  end

  // outputs straight from flops
  for (genvar g = 0; g < NUM_REGS; g++) begin : g_out
    assign o_reg_active[g] = q.active[g];
  end
  assign o_div_active           = q.div_act;
  assign o_powered              = q.powered;
  assign o_pump_output_oe_n     = q.pump_oe_n;
  assign o_rf_enable            = q.rf_en;
  assign o_lock_indicator       = q.lock_ind;
  assign o_test_select_out      = q.mux_out;
  assign o_test_select_out_oe_n = q.mux_oe_n;
endmodule // serial_config_load_port

// file: verification/host_model.sv
`timescale 1ns/1ps
// host on the three-wire bus; link clock idles low outside frames
module host_model (
  // serial pins
  output logic o_sclk,
  output logic o_sdata,
  output logic o_load_strobe
);
  initial {o_sclk, o_sdata, o_load_strobe} = 3'b000;
  // one word msb first, select bits last, then a strobe pulse
  task automatic send(input logic [31:0] w);
    for (int b = 31; b >= 0; b--) begin
      o_sdata = w[b];
      #40 o_sclk = 1'b1;
      #40 o_sclk = 1'b0;
    end
    o_sdata = ~w[0];  // released line shows the inverse
    #40 o_load_strobe = 1'b1;
    #80 o_load_strobe = 1'b0;
    #80;
  endtask
endmodule  // host_model

// file: verification/scl_props.sv
`timescale 1ns/1ps
// watches control pins against committed register values
module scl_props #(
  parameter int WORD_W   = 32,
  parameter int NUM_REGS = 6
) (
  // clock, reset, pins
  input wire logic                 i_mclk,
  input wire logic                 i_rst,
  input wire logic                 i_load_strobe,
  input wire logic                 i_chip_enable,
  input wire logic                 i_rf_mute_n,
  input cfg_port_pkg::pll_status_t i_status,
  // outputs
  input wire logic [WORD_W-1:0]    o_reg_active [NUM_REGS],
  input wire logic                 o_powered,
  input wire logic                 o_pump_output_oe_n,
  input wire logic                 o_rf_enable,
  input wire logic                 o_lock_indicator,
  input wire logic                 o_test_select_out_oe_n
);
  import cfg_port_pkg::*;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  // strobe idle long enough that no commit is pending
  sequence quiet_strobe;
    !i_load_strobe [*8];
  endsequence
  chk_commit_quiet: assert property (quiet_strobe |-> $stable(o_reg_active[1]))
    else $error("register moved with strobe idle");
  chk_pump_off: assert property (!i_chip_enable [*8] |-> o_pump_output_oe_n)
    else $error("pump driven while disabled");
  chk_power_off: assert property (!i_chip_enable [*8] |-> !o_powered)
    else $error("powered while disabled");
  chk_soft_pdn: assert property (o_reg_active[2][R2_PDN_BIT] [*8] |-> !o_powered)
    else $error("powered despite software power-down");
  chk_pin_mute: assert property (!i_rf_mute_n [*8] |-> !o_rf_enable)
    else $error("rf on while mute pin low");
  chk_soft_mute: assert property (!o_reg_active[4][R4_MUTE_BIT] [*8] |-> !o_rf_enable)
    else $error("rf on while software muted");
  chk_lock_high: assert property (i_status.locked [*8] |-> o_lock_indicator)
    else $error("lock indicator low while locked");
  chk_lock_low: assert property (!i_status.locked [*8] |-> !o_lock_indicator)
    else $error("lock indicator high while unlocked");
  chk_mux_tristate: assert property ((o_reg_active[2][28:26] == 3'h0) [*8] |-> o_test_select_out_oe_n)
    else $error("test output driven in tristate mode");
endmodule  // scl_props
bind serial_config_load_port scl_props #(.WORD_W(WORD_W), .NUM_REGS(NUM_REGS)) scl_props_i (
  .i_mclk, .i_rst, .i_load_strobe, .i_chip_enable, .i_rf_mute_n, .i_status, .o_reg_active,
  .o_powered, .o_pump_output_oe_n, .o_rf_enable, .o_lock_indicator, .o_test_select_out_oe_n);

// file: verification/serial_config_load_port_tb.sv
`timescale 1ns/1ps
module serial_config_load_port_tb;
  import cfg_port_pkg::*;
  // pins and outputs
  logic i_mclk = 1'b0, i_rst = 1'b1, i_ce = 1'b1, i_chip_enable = 1'b1, i_rf_mute_n = 1'b1;
  logic i_sclk, i_sdata, i_load_strobe;
  pll_status_t i_status = '0;
  logic [31:0] o_reg_active [6];
  logic [31:0] o_div_active;
  logic o_powered, o_pump_output_oe_n, o_rf_enable, o_lock_indicator, o_test_select_out, o_test_select_out_oe_n;
  int fails = 0;
  int comparisons = 0;
  // each word must land in the register named by its low bits
  logic [31:0] rows [6] = '{32'h5A5A_A5A9, 32'h1000_0002, 32'hC3C3_3C3B, 32'h0000_0024, 32'h7E00_00FD, 32'h0123_4560};
  mux_sel_t sels [3] = '{MUX_REFDIV, MUX_FBDIV, MUX_ALOCK};
  always #5 i_mclk = ~i_mclk;
  serial_config_load_port serial_config_load_port_i (.i_mclk, .i_rst, .i_ce, .i_sclk, .i_sdata, .i_load_strobe,
    .i_chip_enable, .i_rf_mute_n, .i_status, .o_reg_active, .o_div_active, .o_powered, .o_pump_output_oe_n,
    .o_rf_enable, .o_lock_indicator, .o_test_select_out, .o_test_select_out_oe_n);
  host_model host_model_i (.o_sclk(i_sclk), .o_sdata(i_sdata), .o_load_strobe(i_load_strobe));
  // compare words and single bits
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic check_bit(input logic got, input logic exp);
    check({31'h0, got}, {31'h0, exp});
  endtask
  task automatic close_out;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // set control pins at a falling edge and let them settle
  task automatic pins(input logic ce, input logic mn, input logic [2:0] st);
    @(negedge i_mclk);
    {i_chip_enable, i_rf_mute_n, i_status} = {ce, mn, st};
    repeat (8) @(negedge i_mclk);
  endtask
  initial begin
    repeat (2) @(negedge i_mclk);
    i_rst = 1'b0;
    check(o_reg_active[0], REG_RESET);
    check_bit(o_pump_output_oe_n, 1'b1);
    check_bit(o_test_select_out_oe_n, 1'b1);
    $display("reset test done");
    foreach (rows[k]) begin
      host_model_i.send(rows[k]);
      check(o_reg_active[rows[k][2:0]], rows[k]);
    end
    $display("row test done");
    host_model_i.send(32'hFFFF_FFFE);
    host_model_i.send(32'hFFFF_FFFF);
    foreach (rows[k]) check(o_reg_active[rows[k][2:0]], rows[k]);
    // divider change held back until register zero is rewritten
    host_model_i.send(32'h1000_2002);
    host_model_i.send(32'h0030_0024);
    check(o_div_active, 32'h0000_0024);
    host_model_i.send(rows[5]);
    check(o_div_active, 32'h0030_0024);
    $display("buffer test done");
    foreach (sels[k]) begin
      host_model_i.send(32'h0000_0002 | (32'(sels[k]) << R2_MUX_LSB));
      pins(1'b1, 1'b1, 3'b111);
      check_bit(o_test_select_out, 1'b1);
      check_bit(o_test_select_out_oe_n, 1'b0);
      check_bit(o_lock_indicator, 1'b1);
      pins(1'b1, 1'b1, 3'b000);
      check_bit(o_test_select_out, 1'b0);
      check_bit(o_lock_indicator, 1'b0);
    end
    $display("mux test done");
    check_bit(o_rf_enable, 1'b1);
    pins(1'b1, 1'b0, 3'b000);
    check_bit(o_rf_enable, 1'b0);
    pins(1'b0, 1'b1, 3'b000);
    check_bit(o_pump_output_oe_n, 1'b1);
    check_bit(o_powered, 1'b0);
    pins(1'b1, 1'b1, 3'b000);
    check_bit(o_powered, 1'b1);
    check_bit(o_pump_output_oe_n, 1'b0);
    host_model_i.send(32'h0000_0022);
    check_bit(o_powered, 1'b0);
    $display("power test done");
    close_out;
  end
  // cut a hang short
  initial begin
    #200us;
    fails++;
    close_out;
  end
endmodule  // serial_config_load_port_tb
